// ==== src/isr_consts.svh ====
// Purpose: Constants of the status reporting command interpreter
// Assumes: Included by its bare name
// Notes: Keyword codes are the first three upper-case letters of a header keyword
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH
`define ISR_CH_LF 8'h0a
`define ISR_CH_SP 8'h20
`define ISR_CH_TAB 8'h09
`define ISR_CH_STAR 8'h2a
`define ISR_CH_COLON 8'h3a
`define ISR_CH_SEMI 8'h3b
`define ISR_CH_QUERY 8'h3f
`define ISR_CH_DOT 8'h2e
`define ISR_CH_MINUS 8'h2d
`define ISR_CH_ZERO 8'h30
`define ISR_CH_ONE 8'h31
`define ISR_KW_CLS 24'h434c53
`define ISR_KW_ESE 24'h455345
`define ISR_KW_ESR 24'h455352
`define ISR_KW_SRE 24'h535245
`define ISR_KW_STB 24'h535442
`define ISR_KW_IDN 24'h49444e
`define ISR_KW_OPC 24'h4f5043
`define ISR_KW_RST 24'h525354
`define ISR_KW_WAI 24'h574149
`define ISR_KW_STA 24'h535441
`define ISR_KW_OPE 24'h4f5045
`define ISR_KW_QUE 24'h515545
`define ISR_KW_CON 24'h434f4e
`define ISR_KW_ENA 24'h454e41
`define ISR_KW_EVE 24'h455645
`define ISR_KW_PRE 24'h505245
`define ISR_KW_SYS 24'h535953
`define ISR_KW_ERR 24'h455252
`define ISR_KW_AUT 24'h415554
`define ISR_KW_RAN 24'h52414e
`define ISR_KW_MOD 24'h4d4f44
`define ISR_STANDARD_EVENT_LATCH_OPC 0
`define ISR_STANDARD_EVENT_LATCH_EXE 4
`define ISR_STANDARD_EVENT_LATCH_CME 5
`define ISR_STB_EAV 2
`define ISR_STB_QSB 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OSB 7
`define ISR_ERR_CMD 8'h64
`define ISR_ERR_RANGE 8'hde
`define ISR_MASK_MAX 16'h00ff
`define ISR_FUNC_DCV 4'h0
`define ISR_RANGE_RST 16'h03e8
`define ISR_REPLY_LEN 24
`define ISR_GRP_W 16
`endif

// ==== src/isr_pkg.sv ====
// Purpose: Types of the status reporting command interpreter
// Assumes: Constants come from isr_consts.svh
// Notes: None
`include "isr_consts.svh"
package isr_pkg;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WAIT, S_EMIT} isr_fsm_t;
  typedef struct packed {
    logic [2:0] len;
    logic [4:0][7:0] ch;
  } isr_num_t;
  typedef struct packed {
    isr_fsm_t fsm;
    logic [2:0][23:0] kw;
    logic [1:0] kcnt;
    logic [1:0] kidx;
    logic star;
    logic query;
    logic in_arg;
    logic frac;
    logic has_arg;
    logic [15:0] arg;
    logic [7:0] ese;
    logic [7:0] standard_event_latch;
    logic [7:0] sre;
    logic auto_rng;
    logic [3:0] func;
    logic [15:0] rng;
    logic rst_pulse;
    logic opc_pend;
    logic opcq_pend;
    logic [`ISR_REPLY_LEN-1:0][7:0] rbuf;
    logic [4:0] blen;
    logic [4:0] bptr;
  } isr_state_t;
endpackage

// ==== src/isr_byte_queue.sv ====
// Purpose: Flip-flop queue with flush, used for the output and error queues
// Assumes: Pop data is the stored head entry
// Notes: A push into a full queue is held off by o_push_ready
`timescale 1ns/1ps
module isr_byte_queue #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_push_valid,
  output logic o_push_ready,
  input wire logic [W-1:0] i_push_data,
  output logic o_pop_valid,
  input wire logic i_pop_ready,
  output logic [W-1:0] o_pop_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } isr_q_t;
  isr_q_t q_r, q_nxt;
  logic do_push, do_pop;

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("isr_byte_queue needs DEPTH of 2 or more");
  end

  assign o_push_ready = (q_r.cnt != DEPTH[AW:0]);
  assign o_pop_valid = (q_r.cnt != '0);
  assign o_pop_data = q_r.mem[q_r.rd];
  assign do_push = i_push_valid && o_push_ready;
  assign do_pop = o_pop_valid && i_pop_ready;

  always_comb begin
    q_nxt = q_r;
    if (i_flush) begin
      q_nxt.rd = '0;
      q_nxt.wr = '0;
      q_nxt.cnt = '0;
    end else begin
      if (do_push) begin
        q_nxt.mem[q_r.wr] = i_push_data;
        q_nxt.wr = (q_r.wr == AW'(DEPTH - 1)) ? '0 : q_r.wr + 1'b1;
      end
      if (do_pop) begin
        q_nxt.rd = (q_r.rd == AW'(DEPTH - 1)) ? '0 : q_r.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
        q_nxt.cnt = q_r.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        q_nxt.cnt = q_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule // isr_byte_queue

// ==== src/isr_event_group.sv ====
// Purpose: Condition, event latch and enable mask of one status register group
// Assumes: Event bits latch rising condition edges
// Notes: A new edge in the clearing cycle survives the clear
`timescale 1ns/1ps
module isr_event_group #(
  parameter int W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_cond,
  input wire logic i_en_wr,
  input wire logic [W-1:0] i_en_data,
  input wire logic i_evt_rd,
  input wire logic i_clr,
  input wire logic i_preset,
  output logic [W-1:0] o_cond,
  output logic [W-1:0] o_event,
  output logic [W-1:0] o_enable,
  output logic o_summary
);
  typedef struct packed {
    logic [W-1:0] cond;
    logic [W-1:0] evt;
    logic [W-1:0] en;
  } isr_grp_t;
  isr_grp_t g_r, g_nxt;

  if (W < 1 || W > 16) begin : g_chk
    $error("isr_event_group width must be 1 to 16");
  end

  assign o_cond = g_r.cond;
  assign o_event = g_r.evt;
  assign o_enable = g_r.en;
  assign o_summary = |(g_r.evt & g_r.en);

  always_comb begin
    g_nxt = g_r;
    g_nxt.cond = i_cond;
    g_nxt.evt = ((i_evt_rd || i_clr || i_preset) ? '0 : g_r.evt)
      | (i_cond & ~g_r.cond);
    if (i_preset) begin
      g_nxt.en = '0;
    end else if (i_en_wr) begin
      g_nxt.en = i_en_data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end
endmodule // isr_event_group

// ==== src/isr_top.sv ====
// Purpose: Text command interpreter for status, event and housekeeping commands
// Assumes: Bytes arrive from the bus or serial receiver, replies go to its transmitter
// Notes: Keywords match on their first three letters, case-insensitive
//
// Behaviour
// - Clear-status empties output queue, operation, questionable events and event latch.
// - Event summary bit 5 is OR of event latch AND event enable mask.
// - Event enable mask takes 0 to 255; its query returns stored value.
// - Reading the event latch returns its value and clears it.
// - Operation-complete command sets latch bit 0 once pending work finishes.
// - Operation-complete query queues ASCII 1 when done, leaving latch bit alone.
// - Service enable mask takes 0 to 255; bit 6 always reads zero.
// - Status byte query returns the summary bits as decimal 0 to 255.
// - Wait command holds further commands until pending work finishes.
// - Commands run strictly one after another anyway.
// - Reset restores DC voltage on 1000V range with auto-range off, keeping stored status settings.
// - Status preset returns operation and questionable groups to preset state.
// - Both groups offer readable condition, event and read-write enable mask.
// - Error query removes and returns next error queue entry.
// - Identification query returns maker, model, serial and firmware string.
// - Auto-range takes 0 or 1; query returns current state.
// - Calculation query returns sum of active mode weights 1 to 64.
// - Range query returns decimal range value in present function's unit.
// - Bus message ends on line feed or a byte with the end signal.
// - Serial messages and every reply end with a line feed.
`timescale 1ns/1ps
`include "isr_consts.svh"
module isr_top #(
  parameter int OUTQ_DEPTH = 32,
  parameter int ERRQ_DEPTH = 8,
  parameter logic [`ISR_REPLY_LEN*8-1:0] IDN_STR = "MAKER,MODEL0,SN0000,FW00" // Arbitrary
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic i_op_busy,
  input wire logic [`ISR_GRP_W-1:0] i_oper_cond,
  input wire logic [`ISR_GRP_W-1:0] i_ques_cond,
  input wire logic [6:0] i_calc_modes,
  input wire logic [15:0] i_range_val,
  output logic o_srq,
  output logic o_auto_range,
  output logic [3:0] o_func,
  output logic [15:0] o_range,
  output logic o_settings_reset
);
  isr_pkg::isr_state_t s_r, s_nxt;
  logic oq_push, oq_ready, oq_flush;
  logic [7:0] oq_data;
  logic eq_push, eq_pop, eq_valid;
  logic [7:0] eq_data, eq_head;
  logic op_en_wr, op_rd, qu_en_wr, qu_rd, grp_clr, grp_pre;
  logic [`ISR_GRP_W-1:0] grp_en_data;
  logic [`ISR_GRP_W-1:0] op_cond, op_evt, op_en, qu_cond, qu_evt, qu_en;
  logic op_sum, qu_sum, oq_mav;
  logic [7:0] stb_raw, stb;

  if (OUTQ_DEPTH < `ISR_REPLY_LEN || ERRQ_DEPTH < 2) begin : g_chk
    $error("isr_top queue depths too small");
  end

  // Decimal text of a value, most significant digit first
  function automatic isr_pkg::isr_num_t fmt_num(input logic [15:0] v);
    isr_pkg::isr_num_t n;
    logic [4:0][3:0] d;
    n = '0;
    d[0] = 4'(v % 16'd10);
    d[1] = 4'((v / 16'd10) % 16'd10);
    d[2] = 4'((v / 16'd100) % 16'd10);
    d[3] = 4'((v / 16'd1000) % 16'd10);
    d[4] = 4'(v / 16'd10000);
    n.len = (v >= 16'd10000) ? 3'd5 : (v >= 16'd1000) ? 3'd4 :
      (v >= 16'd100) ? 3'd3 : (v >= 16'd10) ? 3'd2 : 3'd1;
    for (int i = 0; i < 5; i++) begin
      if (i < int'(n.len)) begin
        n.ch[i] = `ISR_CH_ZERO | {4'h0, d[int'(n.len) - 1 - i]};
      end
    end
    return n;
  endfunction

  assign oq_mav = o_tx_valid;
  assign stb_raw = {op_sum, 1'b0, |(s_r.standard_event_latch & s_r.ese), oq_mav, qu_sum, eq_valid, 2'b00};
  assign stb = stb_raw | {1'b0, |(stb_raw & s_r.sre), 6'b000000};
  assign o_srq = stb[`ISR_STB_RQS];
  assign o_rx_ready = (s_r.fsm == isr_pkg::S_IDLE);
  assign o_auto_range = s_r.auto_rng;
  assign o_func = s_r.func;
  assign o_range = s_r.rng;
  assign o_settings_reset = s_r.rst_pulse;

  always_comb begin
    logic [7:0] ch;
    logic [19:0] acc;
    logic term, k_op, k_qu;
    isr_pkg::isr_num_t n;
    logic [15:0] rep;
    logic num_rep, bad, rng_bad;
    ch = i_rx_data;
    acc = '0;
    term = 1'b0;
    k_op = 1'b0;
    k_qu = 1'b0;
    n = '0;
    rep = '0;
    num_rep = 1'b0;
    bad = 1'b0;
    rng_bad = 1'b0;
    s_nxt = s_r;
    s_nxt.rst_pulse = 1'b0;
    oq_push = 1'b0;
    oq_data = '0;
    oq_flush = 1'b0;
    eq_push = 1'b0;
    eq_pop = 1'b0;
    eq_data = '0;
    op_en_wr = 1'b0;
    op_rd = 1'b0;
    qu_en_wr = 1'b0;
    qu_rd = 1'b0;
    grp_clr = 1'b0;
    grp_pre = 1'b0;
    grp_en_data = s_r.arg[`ISR_GRP_W-1:0];
    case (s_r.fsm)
      isr_pkg::S_IDLE: begin
        if (i_rx_valid) begin
          term = i_rx_end || (ch == `ISR_CH_LF) || (ch == `ISR_CH_SEMI);
          if (ch >= 8'h61 && ch <= 8'h7a) begin
            ch = ch - 8'h20;
          end
          if (ch == `ISR_CH_STAR && !s_r.in_arg) begin
            s_nxt.star = 1'b1;
          end else if (ch == `ISR_CH_COLON && !s_r.in_arg) begin
            if (s_r.kcnt != 2'd0 && s_r.kidx != 2'd3) begin
              s_nxt.kidx = s_r.kidx + 2'd1;
            end
            s_nxt.kcnt = 2'd0;
          end else if (ch == `ISR_CH_QUERY && !s_r.in_arg) begin
            s_nxt.query = 1'b1;
          end else if ((ch == `ISR_CH_SP || ch == `ISR_CH_TAB) && s_r.kcnt != 2'd0) begin
            s_nxt.in_arg = 1'b1;
          end else if (ch >= 8'h41 && ch <= 8'h5a && !s_r.in_arg) begin
            if (s_r.kcnt != 2'd3 && s_r.kidx != 2'd3) begin
              s_nxt.kw[s_r.kidx] = {s_r.kw[s_r.kidx][15:0], ch};
              s_nxt.kcnt = s_r.kcnt + 2'd1;
            end
          end else if (ch == `ISR_CH_DOT && s_r.in_arg) begin
            s_nxt.frac = 1'b1;
          end else if (ch >= 8'h30 && ch <= 8'h39 && s_r.in_arg && !s_r.frac) begin
            acc = 20'(s_r.arg) * 20'd10 + 20'(ch - `ISR_CH_ZERO);
            s_nxt.arg = (acc > 20'h0ffff) ? 16'hffff : acc[15:0];
            s_nxt.has_arg = 1'b1;
          end
          if (term) begin
            s_nxt.fsm = isr_pkg::S_EXEC;
          end
        end
      end
      isr_pkg::S_EXEC: begin
        s_nxt.fsm = isr_pkg::S_IDLE;
        rng_bad = s_r.arg > `ISR_MASK_MAX;
        if (s_r.kidx == 2'd0 && s_r.kcnt == 2'd0 && !s_r.star) begin
          bad = 1'b0;
        end else if (s_r.star) begin
          case (s_r.kw[0])
            `ISR_KW_CLS: begin
              oq_flush = 1'b1;
              grp_clr = 1'b1;
              s_nxt.standard_event_latch = '0;
            end
            `ISR_KW_ESE: begin
              if (s_r.query) begin
                rep = {8'h00, s_r.ese};
                num_rep = 1'b1;
              end else if (rng_bad || !s_r.has_arg) begin
                rng_bad = 1'b1;
              end else begin
                s_nxt.ese = s_r.arg[7:0];
              end
            end
            `ISR_KW_ESR: begin
              rep = {8'h00, s_r.standard_event_latch};
              num_rep = s_r.query;
              bad = !s_r.query;
              if (s_r.query) begin
                s_nxt.standard_event_latch = '0;
              end
            end
            `ISR_KW_SRE: begin
              if (s_r.query) begin
                rep = {8'h00, s_r.sre};
                num_rep = 1'b1;
              end else if (rng_bad || !s_r.has_arg) begin
                rng_bad = 1'b1;
              end else begin
                s_nxt.sre = s_r.arg[7:0] & 8'hbf;
              end
            end
            `ISR_KW_STB: begin
              rep = {8'h00, stb};
              num_rep = s_r.query;
              bad = !s_r.query;
            end
            `ISR_KW_IDN: begin
              bad = !s_r.query;
              for (int i = 0; i < `ISR_REPLY_LEN; i++) begin
                s_nxt.rbuf[i] = IDN_STR[(`ISR_REPLY_LEN - 1 - i) * 8 +: 8];
              end
              s_nxt.blen = 5'(`ISR_REPLY_LEN);
              s_nxt.bptr = '0;
              if (s_r.query) begin
                s_nxt.fsm = isr_pkg::S_EMIT;
              end
            end
            `ISR_KW_OPC: begin
              s_nxt.opc_pend = !s_r.query;
              s_nxt.opcq_pend = s_r.query;
              s_nxt.fsm = isr_pkg::S_WAIT;
            end
            `ISR_KW_WAI: begin
              s_nxt.fsm = isr_pkg::S_WAIT;
            end
            `ISR_KW_RST: begin
              s_nxt.func = `ISR_FUNC_DCV;
              s_nxt.rng = `ISR_RANGE_RST;
              s_nxt.auto_rng = 1'b0;
              s_nxt.rst_pulse = 1'b1;
            end
            default: begin
              bad = 1'b1;
            end
          endcase
          rng_bad = rng_bad && !s_r.query && (s_r.kw[0] == `ISR_KW_ESE ||
            s_r.kw[0] == `ISR_KW_SRE);
        end else begin
          rng_bad = 1'b0;
          k_op = (s_r.kw[1] == `ISR_KW_OPE);
          k_qu = (s_r.kw[1] == `ISR_KW_QUE);
          if (s_r.kw[0] == `ISR_KW_STA && s_r.kw[1] == `ISR_KW_PRE && !s_r.query) begin
            grp_pre = 1'b1;
          end else if (s_r.kw[0] == `ISR_KW_STA && (k_op || k_qu)) begin
            num_rep = s_r.query;
            case (s_r.kw[2])
              `ISR_KW_CON: begin
                rep = 16'(k_op ? op_cond : qu_cond);
                bad = !s_r.query;
              end
              `ISR_KW_EVE: begin
                rep = 16'(k_op ? op_evt : qu_evt);
                op_rd = k_op && s_r.query;
                qu_rd = k_qu && s_r.query;
                bad = !s_r.query;
              end
              `ISR_KW_ENA: begin
                rep = 16'(k_op ? op_en : qu_en);
                op_en_wr = k_op && !s_r.query && s_r.has_arg;
                qu_en_wr = k_qu && !s_r.query && s_r.has_arg;
                bad = !s_r.query && !s_r.has_arg;
              end
              default: begin
                bad = 1'b1;
              end
            endcase
          end else if (s_r.kw[0] == `ISR_KW_SYS && s_r.kw[1] == `ISR_KW_ERR && s_r.query) begin
            eq_pop = eq_valid;
            n = fmt_num({8'h00, eq_head});
            s_nxt.rbuf = '0;
            if (eq_valid) begin
              s_nxt.rbuf[0] = `ISR_CH_MINUS;
              for (int i = 0; i < 5; i++) begin
                s_nxt.rbuf[i + 1] = n.ch[i];
              end
              s_nxt.blen = 5'(n.len) + 5'd1;
            end else begin
              s_nxt.rbuf[0] = `ISR_CH_ZERO;
              s_nxt.blen = 5'd1;
            end
            s_nxt.bptr = '0;
            s_nxt.fsm = isr_pkg::S_EMIT;
          end else if (s_r.kw[0] == `ISR_KW_CON && s_r.kw[1] == `ISR_KW_AUT) begin
            if (s_r.query) begin
              rep = {15'h0000, s_r.auto_rng};
              num_rep = 1'b1;
            end else if (s_r.has_arg && s_r.arg <= 16'h0001) begin
              s_nxt.auto_rng = s_r.arg[0];
            end else begin
              rng_bad = 1'b1;
            end
          end else if (s_r.kw[0] == `ISR_KW_CON && s_r.kw[1] == `ISR_KW_RAN && s_r.query) begin
            rep = i_range_val;
            num_rep = 1'b1;
          end else if (s_r.kw[0] == `ISR_KW_CON && s_r.kw[1] == `ISR_KW_MOD && s_r.query) begin
            rep = {9'h000, i_calc_modes};
            num_rep = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
        if (num_rep && !bad) begin
          n = fmt_num(rep);
          s_nxt.rbuf = '0;
          for (int i = 0; i < 5; i++) begin
            s_nxt.rbuf[i] = n.ch[i];
          end
          s_nxt.blen = 5'(n.len);
          s_nxt.bptr = '0;
          s_nxt.fsm = isr_pkg::S_EMIT;
        end
        if (bad) begin
          eq_push = 1'b1;
          eq_data = `ISR_ERR_CMD;
          s_nxt.standard_event_latch[`ISR_STANDARD_EVENT_LATCH_CME] = 1'b1;
          s_nxt.fsm = isr_pkg::S_IDLE;
        end else if (rng_bad) begin
          eq_push = 1'b1;
          eq_data = `ISR_ERR_RANGE;
          s_nxt.standard_event_latch[`ISR_STANDARD_EVENT_LATCH_EXE] = 1'b1;
        end
        s_nxt.kw = '0;
        s_nxt.kcnt = '0;
        s_nxt.kidx = '0;
        s_nxt.star = 1'b0;
        s_nxt.query = 1'b0;
        s_nxt.in_arg = 1'b0;
        s_nxt.frac = 1'b0;
        s_nxt.has_arg = 1'b0;
        s_nxt.arg = '0;
      end
      isr_pkg::S_WAIT: begin
        if (!i_op_busy) begin
          s_nxt.opc_pend = 1'b0;
          s_nxt.opcq_pend = 1'b0;
          s_nxt.fsm = isr_pkg::S_IDLE;
          if (s_r.opc_pend) begin
            s_nxt.standard_event_latch[`ISR_STANDARD_EVENT_LATCH_OPC] = 1'b1;
          end
          if (s_r.opcq_pend) begin
            s_nxt.rbuf = '0;
            s_nxt.rbuf[0] = `ISR_CH_ONE;
            s_nxt.blen = 5'd1;
            s_nxt.bptr = '0;
            s_nxt.fsm = isr_pkg::S_EMIT;
          end
        end
      end
      isr_pkg::S_EMIT: begin
        oq_push = 1'b1;
        oq_data = (s_r.bptr == s_r.blen) ? `ISR_CH_LF : s_r.rbuf[s_r.bptr];
        if (oq_ready) begin
          s_nxt.bptr = s_r.bptr + 5'd1;
          if (s_r.bptr == s_r.blen) begin
            s_nxt.fsm = isr_pkg::S_IDLE;
          end
        end
      end
      default: begin
        s_nxt.fsm = isr_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.func <= `ISR_FUNC_DCV;
      s_r.rng <= `ISR_RANGE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  isr_byte_queue #(.W(8), .DEPTH(OUTQ_DEPTH)) u_outq (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_flush(oq_flush),
    .i_push_valid(oq_push),
    .o_push_ready(oq_ready),
    .i_push_data(oq_data),
    .o_pop_valid(o_tx_valid),
    .i_pop_ready(i_tx_ready),
    .o_pop_data(o_tx_data)
  );

  isr_byte_queue #(.W(8), .DEPTH(ERRQ_DEPTH)) u_errq (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_flush(1'b0),
    .i_push_valid(eq_push),
    .o_push_ready(),
    .i_push_data(eq_data),
    .o_pop_valid(eq_valid),
    .i_pop_ready(eq_pop),
    .o_pop_data(eq_head)
  );

  isr_event_group #(.W(`ISR_GRP_W)) u_oper (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_cond(i_oper_cond),
    .i_en_wr(op_en_wr),
    .i_en_data(grp_en_data),
    .i_evt_rd(op_rd),
    .i_clr(grp_clr),
    .i_preset(grp_pre),
    .o_cond(op_cond),
    .o_event(op_evt),
    .o_enable(op_en),
    .o_summary(op_sum)
  );

  isr_event_group #(.W(`ISR_GRP_W)) u_ques (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_cond(i_ques_cond),
    .i_en_wr(qu_en_wr),
    .i_en_data(grp_en_data),
    .i_evt_rd(qu_rd),
    .i_clr(grp_clr),
    .i_preset(grp_pre),
    .o_cond(qu_cond),
    .o_event(qu_evt),
    .o_enable(qu_en),
    .o_summary(qu_sum)
  );
endmodule // isr_top

// ==== verification/isr_top_asserts.sv ====
// Purpose: Port checks of isr_top
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every isr_top
`timescale 1ns/1ps
module isr_top_asserts (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic o_srq,
  input wire logic o_auto_range,
  input wire logic [3:0] o_func,
  input wire logic [15:0] o_range,
  input wire logic o_settings_reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence take_s;
    o_rx_ready && i_rx_valid;
  endsequence
  sequence dflt_s;
    o_range == 16'h03e8 && o_func == 4'h0 && !o_auto_range;
  endsequence
  reset_vals_a: assert property ($past(i_sys_rst) |-> dflt_s and o_rx_ready && !o_srq)
    else $error("values after reset wrong");
  lf_ends_a: assert property (take_s ##0 i_rx_data == 8'h0a |=> !o_rx_ready)
    else $error("line feed did not end message");
  end_ends_a: assert property (take_s ##0 i_rx_end |=> !o_rx_ready)
    else $error("end signal did not end message");
  fall_cause_a: assert property ($fell(o_rx_ready) |-> $past(i_rx_valid
    && (i_rx_data == 8'h0a || i_rx_data == 8'h3b || i_rx_end)))
    else $error("intake stopped without terminator");
  pulse_one_a: assert property (o_settings_reset |=> !o_settings_reset)
    else $error("settings reset pulse too long");
  rst_apply_a: assert property (o_settings_reset |-> ##[0:1] dflt_s)
    else $error("reset command left settings");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready && o_rx_ready
    |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte lost while stalled");
  tx_rise_a: assert property ($rose(o_tx_valid) |-> $past(!o_rx_ready))
    else $error("reply without command");
endmodule // isr_top_asserts
bind isr_top isr_top_asserts chk (.i_clk_sys, .i_sys_rst, .i_rx_valid, .i_rx_data,
  .i_rx_end, .o_rx_ready, .o_tx_valid, .o_tx_data, .i_tx_ready, .o_srq,
  .o_auto_range, .o_func, .o_range, .o_settings_reset);

// ==== verification/isr_host_sink.sv ====
// Purpose: Controller side that takes reply bytes
// Assumes: Reply text is read and cleared by the bench
// Notes: Slow mode takes one byte in three
`timescale 1ns/1ps
module isr_host_sink (
  input wire logic i_clk_sys,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  string got = "";
  int n_msg = 0;
  int tick = 0;
  assign o_tx_ready = !i_slow || (tick % 3 == 0);
  always @(posedge i_clk_sys) begin
    tick <= tick + 1;
    if (i_tx_valid && o_tx_ready) begin
      got = {got, string'(i_tx_data)};
      if (i_tx_data == 8'h0a) n_msg++;
    end
  end
endmodule // isr_host_sink

// ==== verification/isr_top_test.sv ====
// Purpose: Self-checking bench of isr_top
// Assumes: Commands go in as text, replies come back through the sink
// Notes: Ordinary commands run from a table
`timescale 1ns/1ps
module isr_top_test;
  typedef struct {string c; string r;} isr_row_t;
  logic i_clk_sys, i_sys_rst, i_rx_valid, i_rx_end, i_op_busy, slow;
  logic o_rx_ready, o_tx_valid, i_tx_ready, o_srq, o_auto_range, o_settings_reset;
  logic [7:0] i_rx_data, o_tx_data;
  logic [15:0] i_oper_cond, i_ques_cond, i_range_val, o_range;
  logic [6:0] i_calc_modes;
  logic [3:0] o_func;
  int n_errors = 0;
  int tests_run = 0;
  isr_row_t rows [34] = '{
    '{"*ESE 130", ""}, '{"*ESE?", "130"}, '{"*SRE 255", ""}, '{"*SRE?", "191"},
    '{"*ESE 256", ""}, '{"*ESE?", "130"}, '{"*STB?", "68"}, '{"*ESR?", "16"},
    '{"*ESR?", "0"}, '{":SYST:ERR?", "-222"}, '{":SYST:ERR?", "0"},
    '{"*STB?", "0"}, '{"*OPC?", "1"}, '{"*ESR?", "0"}, '{"*OPC", ""}, '{"*ESR?", "1"},
    '{":CONF:AUT 1", ""}, '{":CONF:AUT 2", ""}, '{":CONF:AUT?", "1"},
    '{":SYST:ERR?", "-222"}, '{":CONF:MOD?", "85"}, '{":CONF:RAN?", "50"},
    '{":STAT:OPER:COND?", "1"}, '{":STAT:OPER:EVEN?", "1"}, '{":STAT:OPER:EVEN?", "0"},
    '{":STAT:OPER:ENAB 5", ""}, '{":STAT:OPER:ENAB?", "5"}, '{":STAT:PRES", ""},
    '{":STAT:OPER:ENAB?", "0"}, '{"*IDN?", "MKR,MODEL1,SN1234,FW0001"},
    '{"*ESE 16", ""}, '{"*ESE 999", ""}, '{"*STB?", "100"}, '{"*CLS", ""}};
  isr_top #(.IDN_STR("MKR,MODEL1,SN1234,FW0001")) dut (.i_clk_sys, .i_sys_rst, .i_rx_valid,
    .i_rx_data, .i_rx_end, .o_rx_ready, .o_tx_valid, .o_tx_data, .i_tx_ready, .i_op_busy,
    .i_oper_cond, .i_ques_cond, .i_calc_modes, .i_range_val, .o_srq,
    .o_auto_range, .o_func, .o_range, .o_settings_reset);
  isr_host_sink sink (.i_clk_sys, .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic miss(string g, string e);
    n_errors++;
    $display("mismatch at %0t got %h expected %h", $time, g, e);
  endtask
  task automatic check_str(string g, string e);
    tests_run++;
    if (g != e) miss(g, e);
  endtask
  task automatic check_val(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) miss($sformatf("%h", g), $sformatf("%h", e));
  endtask
  task automatic wait_ready(int n0, logic rep);
    int k;
    k = 0;
    while ((o_rx_ready !== 1'b1 || (rep && sink.n_msg == n0)) && k < 900) begin
      @(posedge i_clk_sys);
      k++;
    end
    if (k >= 900) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic send(string s, logic e);
    for (int i = 0; i < s.len(); i++) begin
      i_rx_valid <= 1'b1;
      i_rx_data <= s[i];
      i_rx_end <= e && (i == s.len() - 1);
      @(posedge i_clk_sys);
      wait_ready(0, 1'b0);
    end
    i_rx_valid <= 1'b0;
    i_rx_end <= 1'b0;
  endtask
  task automatic do_cmd(string c, string r);
    int n0;
    sink.got = "";
    n0 = sink.n_msg;
    send({c, "\n"}, 1'b0);
    repeat (2) @(posedge i_clk_sys);
    wait_ready(n0, r != "");
    check_str(sink.got, r == "" ? "" : {r, "\n"});
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    {i_sys_rst, i_rx_valid, i_rx_data, i_rx_end, i_op_busy, slow} = 13'h1000;
    {i_oper_cond, i_ques_cond, i_range_val, i_calc_modes} = {16'h0000, 16'h0000, 16'h0032, 7'h55};
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    i_oper_cond <= 16'h0001;
    @(posedge i_clk_sys);
    check_val({o_range, o_func, o_tx_valid}, 32'h00007d00);
    $display("reset test done");
    for (int i = 0; i < 34; i++) begin
      slow <= i[0];
      do_cmd(rows[i].c, rows[i].r);
    end
    check_val(o_srq, 32'h00000001);
    $display("table test done");
    i_op_busy <= 1'b1;
    send("*WAI\n", 1'b0);
    repeat (20) @(posedge i_clk_sys);
    check_val(o_rx_ready, 16'h0000);
    i_op_busy <= 1'b0;
    do_cmd("*OPC?", "1");
    send("*ESE 7", 1'b1);
    do_cmd("*ESE?", "7");
    check_val(o_auto_range, 16'h0001);
    i_ques_cond <= 16'h0004;
    do_cmd(":STAT:QUES:COND?", "4");
    do_cmd("*CLS", "");
    do_cmd(":STAT:QUES:EVEN?", "0");
    do_cmd("*RST", "");
    check_val({o_range, o_func, o_auto_range}, 32'h00007d00);
    $display("hand tests done");
    final_report();
  end
endmodule // isr_top_test
